/* File: src/core_flags_pkg.sv */
/*
 * constants for the core flags and program counter block.
 * assumes a decoder that issues one operation per strobe cycle.
 */
package core_flags_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_PROGRAM_STATUS = 8'h86;
   localparam logic [7:0] ADDR_PC_LOW         = 8'hce;
   localparam logic [7:0] ADDR_PC_HIGH        = 8'hcf;
   localparam logic [7:0] ADDR_WORK_REG       = 8'h90;

   // ****************************************
   // status fields
   // ****************************************
   localparam int POS_CAUSE_HI = 7;
   localparam int POS_CAUSE_LO = 6;
   localparam int POS_CARRY    = 2;
   localparam int POS_NIBBLE   = 1;
   localparam int POS_ZERO     = 0;
   localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
   localparam logic [1:0] CAUSE_RESERVED = 2'h1;
   localparam logic [1:0] CAUSE_LOW_VOLT = 2'h2;
   localparam logic [1:0] CAUSE_PIN      = 2'h3;
   localparam logic [7:0] STATUS_WMASK   = 8'hc7;

   // ****************************************
   // reset values and widths
   // ****************************************
   localparam int PC_W = 11;
   localparam logic [10:0] PC_RESET   = 11'h000;
   localparam logic [7:0]  WORK_RESET = 8'h00;
   localparam logic [10:0] PC_STEP    = 11'h001;
   localparam logic [10:0] PC_SKIP    = 11'h002;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE  = 4'h0,
      OP_ADD   = 4'h1,
      OP_ADC   = 4'h2,
      OP_SUB   = 4'h3,
      OP_AND   = 4'h4,
      OP_OR    = 4'h5,
      OP_XOR   = 4'h6,
      OP_RLC   = 4'h7,
      OP_RRC   = 4'h8,
      OP_CMP   = 4'h9,
      OP_INC   = 4'ha,
      OP_DEC   = 4'hb,
      OP_MOV   = 4'hc,
      OP_BTST  = 4'hd
   } alu_op_e;

   typedef enum logic [2:0] {
      FL_JUMP = 3'h0,
      FL_SEQ  = 3'h1,
      FL_LOAD = 3'h2,
      FL_SKIP = 3'h3
   } flow_t_unused_e;

endpackage : core_flags_pkg

/* File: src/core_flags_and_program_counter.sv */
/*
 * working register, status flags and 11-bit program counter of the core.
 * assumes the decoder gives one strobe per executed instruction and that
 * data memory answers the register port in the cycle after a read.
 * reset cause comes from an outside supervisor and survives RESET.
 * a true skip is taken by the counter alone; the skipped word is never fetched.
 */
//
// Operation
// - 8-bit working register moves data between ALU and memory, mapped at 90h.
// - ALU operations update zero, carry and nibble carry flags.
// - interrupt entry touches only the program counter, not work or status.
// - push saves work and status to buffers; pop restores both.
// - status at 86h: cause bits 7:6, carry 2, nibble 1, zero 0.
// - cause code 00 watchdog, 01 reserved, 10 low voltage, 11 pin.
// - carry set on add carry, sub no borrow, rotate out 1, compare >= 0.
// - nibble carry set on low nibble carry or no high nibble borrow.
// - zero flag set when operation result is zero, else cleared.
// - 11-bit counter, 3-bit high, 8-bit low, zero on reset, gives fetch address.
// - counter advances by one per instruction.
// - jump or call loads destination into counter bits 0 to 10.
// - four skip operations (bit test, compare, increment, decrement) advance counter by two when true.
// - bit test skips when tested bit matches expected value.
// - compare skip when work equals operand.
// - increment skip when result wraps from ff to 00.
// - decrement skip when result wraps from 00 to ff.
// - add into low counter byte carries into high byte.
// - borrow from low counter byte leaves high byte unchanged.
`timescale 1ns/1ps
module core_flags_and_program_counter
   import core_flags_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RESET,
   // reset cause from supervisor
   input  wire logic [1:0]  RESET_CAUSE,
   input  wire logic        CAUSE_LOAD,
   // instruction strobe from decoder
   input  wire logic        EXEC,
   input  wire logic [3:0]  ALU_OP,
   input  wire logic [7:0]  OPERAND,
   input  wire logic        DEST_WORK,
   input  wire logic        DEST_PC_LOW,
   input  wire logic        SKIP_INSN,
   input  wire logic        BIT_EXPECT,
   input  wire logic [2:0]  BIT_SEL,
   input  wire logic        JUMP,
   input  wire logic [10:0] JUMP_ADDR,
   input  wire logic        INT_ENTRY,
   input  wire logic [10:0] INT_VECTOR,
   input  wire logic        PUSH,
   input  wire logic        POP,
   // register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   // results
   output logic      [10:0] FETCH_ADDR,
   output logic      [7:0]  WORK,
   output logic      [7:0]  STATUS,
   output logic      [7:0]  MEM_WDATA,
   output logic             MEM_WE
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0]  work_ff;
   logic [1:0]  cause_ff;
   logic        carry_ff;
   logic        nibble_ff;
   logic        zero_ff;
   logic [2:0]  pch_ff;
   logic [7:0]  pcl_ff;
   logic [7:0]  save_work_ff;
   logic [7:0]  save_status_ff;
   logic        skip_pend_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  memw_ff;
   logic        memwe_ff;

   // ****************************************
   // alu
   // ****************************************
   logic [8:0]  res9;
   logic [4:0]  nib5;
   logic [7:0]  res;
   logic        nxt_carry;
   logic        nxt_nibble;
   logic        cond_true;
   logic        flags_on;
   logic        live;
   logic [7:0]  status_word;
   logic [10:0] pc_now;

   // skipped slot is discarded wholesale, no flag or memory effect
   // interrupt entry owns the cycle: only the counter moves
   assign live = EXEC && !skip_pend_ff && !INT_ENTRY;
   assign pc_now = {pch_ff, pcl_ff};
   assign status_word = {cause_ff, 3'h0, carry_ff, nibble_ff, zero_ff};

   // ****************************************
   // instruction qualifiers
   // ****************************************
   logic        op_is_test;
   logic        op_is_pc_add;
   logic        op_has_result;
   logic        work_we;
   logic        pcl_we;
   logic        mem_we_next;
   logic        status_wr;
   logic        work_wr;
   logic        pcl_wr;
   logic        pch_wr;

   // compare and bit test store no result; compare still updates the flags
   assign op_is_test    = (ALU_OP == OP_CMP) || (ALU_OP == OP_BTST);
   assign op_is_pc_add  = (ALU_OP == OP_ADD) || (ALU_OP == OP_ADC);
   assign op_has_result = !op_is_test && (ALU_OP != OP_NONE);
   // work is written by pop, by this strobe and by a register write to 90h
   assign work_we       = live && DEST_WORK && !op_is_test;
   // any stored result aimed at the low byte is a computed jump
   assign pcl_we        = live && DEST_PC_LOW && !op_is_test;
   // a result bound for neither work nor counter lands in data memory
   assign mem_we_next   = live && op_has_result && !DEST_WORK && !DEST_PC_LOW && !JUMP && !PUSH && !POP;
   // software writes lose to an executing instruction on the same target
   assign status_wr     = REG_WR && (REG_ADDR == ADDR_PROGRAM_STATUS);
   assign work_wr       = REG_WR && (REG_ADDR == ADDR_WORK_REG);
   assign pcl_wr        = REG_WR && (REG_ADDR == ADDR_PC_LOW);
   assign pch_wr        = REG_WR && (REG_ADDR == ADDR_PC_HIGH);

   // ****************************************
   // bit tap for the bit test skips
   // ****************************************
   logic [7:0]  bit_hit;
   logic        bit_match;

   // one comparator per operand bit instead of a variable index
   for (genvar b = 0; b < 8; b++) begin : g_bit_tap
      assign bit_hit[b] = (BIT_SEL == 3'(b)) && (OPERAND[b] == BIT_EXPECT);
   end
   assign bit_match = |bit_hit;

   // ****************************************
   // register read select
   // ****************************************
   logic [7:0]  rd_sel;

   // unmapped addresses read as zero
   always_comb begin
      rd_sel = 8'h00;
      case (REG_ADDR)
         ADDR_PROGRAM_STATUS: rd_sel = status_word;
         ADDR_PC_LOW:         rd_sel = pcl_ff;
         ADDR_PC_HIGH:        rd_sel = {5'h00, pch_ff};
         ADDR_WORK_REG:       rd_sel = work_ff;
         default:             rd_sel = 8'h00;
      endcase
   end

   always_comb begin
      res9       = 9'h000;
      nib5       = 5'h00;
      nxt_carry  = carry_ff;
      nxt_nibble = nibble_ff;
      flags_on   = 1'b1;
      cond_true  = 1'b0;
      case (ALU_OP)
         OP_ADD: begin
            res9 = {1'b0, work_ff} + {1'b0, OPERAND};
            nib5 = {1'b0, work_ff[3:0]} + {1'b0, OPERAND[3:0]};
            nxt_carry  = res9[8];
            nxt_nibble = nib5[4];
         end
         OP_ADC: begin
            res9 = {1'b0, work_ff} + {1'b0, OPERAND} + {8'h00, carry_ff};
            nib5 = {1'b0, work_ff[3:0]} + {1'b0, OPERAND[3:0]} + {4'h0, carry_ff};
            nxt_carry  = res9[8];
            nxt_nibble = nib5[4];
         end
         OP_SUB, OP_CMP: begin
            // operand minus work; no borrow sets carry
            res9 = {1'b0, OPERAND} - {1'b0, work_ff};
            nib5 = {1'b0, OPERAND[3:0]} - {1'b0, work_ff[3:0]};
            nxt_carry  = ~res9[8];
            nxt_nibble = ~nib5[4];
            cond_true  = (ALU_OP == OP_CMP) && (OPERAND == work_ff);
         end
         OP_AND: res9 = {1'b0, work_ff & OPERAND};
         OP_OR:  res9 = {1'b0, work_ff | OPERAND};
         OP_XOR: res9 = {1'b0, work_ff ^ OPERAND};
         // rotates keep the nibble carry
         OP_RLC: begin
            res9 = {1'b0, OPERAND[6:0], carry_ff};
            nxt_carry = OPERAND[7];
         end
         OP_RRC: begin
            res9 = {1'b0, carry_ff, OPERAND[7:1]};
            nxt_carry = OPERAND[0];
         end
         OP_INC: begin
            res9 = {1'b0, OPERAND} + 9'h001;
            cond_true = (OPERAND == 8'hff);
         end
         OP_DEC: begin
            res9 = {1'b0, OPERAND} - 9'h001;
            cond_true = (OPERAND == 8'h00);
         end
         OP_MOV: begin
            res9 = {1'b0, OPERAND};
            flags_on = 1'b0;
         end
         OP_BTST: begin
            res9 = 9'h000;
            flags_on = 1'b0;
            cond_true = bit_match;
         end
         default: flags_on = 1'b0;
      endcase
   end
   assign res = res9[7:0];

   // ****************************************
   // flag and counter arithmetic
   // ****************************************
   logic        nxt_zero;
   logic [10:0] pc_plus_one;
   logic [10:0] pc_plus_two;
   logic [2:0]  pch_carried;

   // zero looks at the 8-bit result only; the carry out has its own flag
   assign nxt_zero    = (res == 8'h00);
   assign pc_plus_one = pc_now + PC_STEP;
   assign pc_plus_two = pc_now + PC_SKIP;
   // only an upward carry out of the low byte reaches the high byte
   assign pch_carried = pch_ff + {2'h0, res9[8]};

   // ****************************************
   // working register and save buffers
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         work_ff <= WORK_RESET;
      end else if (live && POP) begin
         work_ff <= save_work_ff;
      end else if (work_we) begin
         work_ff <= res;
      end else if (work_wr) begin
         work_ff <= REG_WDATA;
      end
   end

   // interrupt entry never writes these buffers
   // one level only: a second push overwrites the first
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         save_work_ff   <= WORK_RESET;
         save_status_ff <= 8'h00;
      end else if (live && PUSH) begin
         save_work_ff   <= work_ff;
         save_status_ff <= status_word;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         carry_ff  <= 1'b0;
         nibble_ff <= 1'b0;
         zero_ff   <= 1'b0;
      end else if (live && POP) begin
         carry_ff  <= save_status_ff[POS_CARRY];
         nibble_ff <= save_status_ff[POS_NIBBLE];
         zero_ff   <= save_status_ff[POS_ZERO];
      end else if (live && flags_on) begin
         carry_ff  <= nxt_carry;
         nibble_ff <= nxt_nibble;
         zero_ff   <= nxt_zero;
      end else if (status_wr) begin
         // software lands only when no instruction owns the flags
         carry_ff  <= REG_WDATA[POS_CARRY];
         nibble_ff <= REG_WDATA[POS_NIBBLE];
         zero_ff   <= REG_WDATA[POS_ZERO];
      end
   end

   // cause survives its own reset, so it is loaded by the supervisor strobe
   always_ff @(posedge MCLK) begin
      if (CAUSE_LOAD) begin
         cause_ff <= RESET_CAUSE;
      end else if (RESET) begin
         cause_ff <= cause_ff;
      end else if (live && POP) begin
         cause_ff <= save_status_ff[POS_CAUSE_HI:POS_CAUSE_LO];
      end else if (status_wr) begin
         cause_ff <= REG_WDATA[POS_CAUSE_HI:POS_CAUSE_LO];
      end
   end

   // ****************************************
   // program counter
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         {pch_ff, pcl_ff} <= PC_RESET;
         skip_pend_ff     <= 1'b0;
      end else if (INT_ENTRY) begin
         {pch_ff, pcl_ff} <= INT_VECTOR;
         skip_pend_ff     <= 1'b0;
      end else if (EXEC) begin
         skip_pend_ff <= 1'b0;
         if (!live) begin
            {pch_ff, pcl_ff} <= pc_plus_one;
         end else if (JUMP) begin
            {pch_ff, pcl_ff} <= JUMP_ADDR;
         end else if (pcl_we && op_is_pc_add) begin
            pcl_ff <= res;
            pch_ff <= pch_carried;
         end else if (pcl_we) begin
            // a borrow out of the low byte is dropped on purpose
            pcl_ff <= res;
         end else if (SKIP_INSN && cond_true) begin
            {pch_ff, pcl_ff} <= pc_plus_two;
         end else begin
            {pch_ff, pcl_ff} <= pc_plus_one;
         end
      end else if (pcl_wr) begin
         pcl_ff <= REG_WDATA;
      end else if (pch_wr) begin
         pch_ff <= REG_WDATA[2:0];
      end
   end

   // ****************************************
   // memory write of results bound for neither work nor counter
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         memw_ff  <= 8'h00;
         memwe_ff <= 1'b0;
      end else begin
         memw_ff  <= res;
         memwe_ff <= mem_we_next;
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rdata_ff <= 8'h00;
      end else if (REG_RD) begin
         rdata_ff <= rd_sel;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // ****************************************
   // outputs, all straight from flip-flops
   // ****************************************
   assign REG_RDATA  = rdata_ff;
   assign FETCH_ADDR = pc_now;
   assign WORK       = work_ff;
   assign STATUS     = status_word;
   assign MEM_WDATA  = memw_ff;
   assign MEM_WE     = memwe_ff;

endmodule : core_flags_and_program_counter

/* File: test/core_flags_checker.sv */
/* port assertions for the core flags and program counter.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module core_flags_checker
   import core_flags_pkg::*;
(
   // control
   input wire logic        MCLK, RESET, CAUSE_LOAD, EXEC, DEST_WORK, DEST_PC_LOW,
   input wire logic        SKIP_INSN, JUMP, INT_ENTRY, REG_WR, REG_RD, MEM_WE,
   // data
   input wire logic [3:0]  ALU_OP,
   input wire logic [7:0]  OPERAND, REG_ADDR, REG_RDATA, WORK, STATUS, MEM_WDATA,
   input wire logic [10:0] JUMP_ADDR, INT_VECTOR, FETCH_ADDR
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   logic plain;
   assign plain = EXEC && !JUMP && !INT_ENTRY && !SKIP_INSN && !DEST_PC_LOW;

   AST_RESET_STATE: assert property ($fell(RESET) |-> FETCH_ADDR == 11'h000 && WORK == 8'h00
      && STATUS[2:0] == 3'h0)
      else $error("state not cleared by reset");
   AST_PC_STEP: assert property (plain |=> FETCH_ADDR == $past(FETCH_ADDR) + 11'h001)
      else $error("counter did not step by one");
   AST_JUMP_LOAD: assert property (EXEC && JUMP && !INT_ENTRY |=> FETCH_ADDR == $past(JUMP_ADDR))
      else $error("jump target not loaded");
   AST_INT_ONLY_PC: assert property (INT_ENTRY && !CAUSE_LOAD && !REG_WR |=>
      FETCH_ADDR == $past(INT_VECTOR) && $stable(WORK) && $stable(STATUS))
      else $error("interrupt touched work or status");
   AST_CMP_SKIP: assert property (EXEC && SKIP_INSN && ALU_OP == OP_CMP && OPERAND == WORK
      && !JUMP && !INT_ENTRY |=> FETCH_ADDR == $past(FETCH_ADDR) + 11'h002)
      else $error("equal compare did not skip");
   AST_INC_WRAP: assert property (EXEC && SKIP_INSN && ALU_OP == OP_INC && OPERAND == 8'hff && !DEST_WORK
      && !DEST_PC_LOW && !JUMP && !INT_ENTRY
      |=> MEM_WE && MEM_WDATA == 8'h00 && FETCH_ADDR == $past(FETCH_ADDR) + 11'h002)
      else $error("increment wrap did not skip");
   AST_ZERO_FLAG: assert property (EXEC && DEST_WORK && !SKIP_INSN && !INT_ENTRY
      && ALU_OP inside {[4'h1:4'h6]} |=> STATUS[0] == (WORK == 8'h00))
      else $error("zero flag wrong");
   AST_SUB_KEEP_HIGH: assert property (EXEC && DEST_PC_LOW && ALU_OP == OP_SUB && !JUMP && !INT_ENTRY
      |=> FETCH_ADDR[10:8] == $past(FETCH_ADDR[10:8])) else $error("borrow changed counter high");
   AST_READ_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data outside read slot");
   AST_STATUS_READ: assert property (REG_RD && REG_ADDR == ADDR_PROGRAM_STATUS && !EXEC
      && !CAUSE_LOAD && !REG_WR |=> REG_RDATA == STATUS && STATUS[5:3] == 3'h0)
      else $error("status read mismatch");

   cover property (EXEC && JUMP);
   cover property (EXEC && SKIP_INSN ##1 MEM_WE);
   cover property (REG_RD ##1 REG_RDATA != 8'h00);
endmodule : core_flags_checker

bind core_flags_and_program_counter core_flags_checker chk_i (.MCLK, .RESET, .CAUSE_LOAD, .EXEC, .DEST_WORK,
   .DEST_PC_LOW, .SKIP_INSN, .JUMP, .INT_ENTRY, .REG_WR, .REG_RD, .MEM_WE, .ALU_OP, .OPERAND, .REG_ADDR,
   .REG_RDATA, .WORK, .STATUS, .MEM_WDATA, .JUMP_ADDR, .INT_VECTOR, .FETCH_ADDR);

/* File: test/data_mem_model.sv */
/* data memory stand-in: keeps the last byte the core wrote.
   assumes single-cycle write strobes. */
`timescale 1ns/1ps
module data_mem_model (
   // clock
   input wire logic       mclk,
   // write side
   input wire logic       mem_we,
   input wire logic [7:0] mem_wdata,
   // observed
   output logic     [7:0] last_wr
);
   // no reset: the memory keeps its contents across a core reset
   always_ff @(posedge mclk) begin
      if (mem_we) begin
         last_wr <= mem_wdata;
      end
   end
endmodule : data_mem_model

/* File: test/tb.sv */
/* self-checking bench for the core flags and program counter.
   assumes the bound checker and the memory model on the write port. */
`timescale 1ns/1ps
module tb
   import core_flags_pkg::*;
;
   logic        mclk, rst, cause_ld, exec, d_work, d_pcl, skip, bexp, jump, int_e, push, pop, wr, rd, mem_we;
   logic [1:0]  cause;
   logic [2:0]  bsel, ef;
   logic [3:0]  op;
   logic [7:0]  opnd, addr, wdata, rdata, work, status, mem_wdata, last_wr, ew, d;
   logic [10:0] jaddr, ivec, pc, epc, r, sv, pushed;
   int          fail_count = 0, check_count = 0, cyc = 0;
   localparam logic [6:0] F_WORK = 7'h40, F_PCL = 7'h20, F_SKIP = 7'h10, F_JUMP = 7'h08, F_INT = 7'h04;
   localparam alu_op_e CORNER_OP [7] = '{OP_AND, OP_OR, OP_ADD, OP_SUB, OP_ADD, OP_ADD, OP_ADC};
   localparam logic [7:0] CORNER_X [7] = '{8'h00, 8'hff, 8'h01, 8'h00, 8'h0f, 8'h01, 8'hff};
   localparam alu_op_e OPS [6] = '{OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_XOR};

   core_flags_and_program_counter dut (.MCLK(mclk), .RESET(rst), .RESET_CAUSE(cause), .CAUSE_LOAD(cause_ld),
      .EXEC(exec), .ALU_OP(op), .OPERAND(opnd), .DEST_WORK(d_work), .DEST_PC_LOW(d_pcl), .SKIP_INSN(skip),
      .BIT_EXPECT(bexp), .BIT_SEL(bsel), .JUMP(jump), .JUMP_ADDR(jaddr), .INT_ENTRY(int_e), .INT_VECTOR(ivec),
      .PUSH(push), .POP(pop), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .FETCH_ADDR(pc), .WORK(work), .STATUS(status), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we));
   data_mem_model mem (.mclk(mclk), .mem_we(mem_we), .mem_wdata(mem_wdata), .last_wr(last_wr));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [10:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // {c, dc, z, result}; logic ops keep c and dc
   function automatic logic [10:0] alu(input logic [3:0] o, input logic [7:0] w, x, input logic [2:0] f);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, w} + {1'b0, x} + {8'h00, o == OP_ADC && f[2]};
      n = {1'b0, w[3:0]} + {1'b0, x[3:0]} + {4'h0, o == OP_ADC && f[2]};
      case (o)
         OP_AND, OP_OR, OP_XOR: begin
            s = {f[2], o == OP_AND ? w & x : (o == OP_OR ? w | x : w ^ x)};
            n = {f[1], 4'h0};
         end
         OP_SUB: begin
            s = {x >= w, x - w};
            n = {x[3:0] >= w[3:0], 4'h0};
         end
         OP_RLC, OP_RRC: begin
            s = (o == OP_RLC) ? {x, f[2]} : {x[0], f[2], x[7:1]};
            n = {f[1], 4'h0};
         end
         default: ;
      endcase
      return {s[8], n[4], s[7:0] == 8'h00, s[7:0]};
   endfunction : alu
   task automatic run(input logic [3:0] o, input logic [7:0] x, input logic [6:0] f);
      @(posedge mclk);
      exec <= 1'b1;
      op <= o;
      opnd <= x;
      {d_work, d_pcl, skip, jump, int_e, push, pop} <= f;
      @(posedge mclk);
      exec <= 1'b0;
      {d_work, d_pcl, skip, jump, int_e, push, pop} <= 7'h00;
      #1;
      if (!f[3] && !f[2]) epc = epc + ((f[4] && r[0]) ? 11'h002 : 11'h001);
   endtask : run
   task automatic alu_step(input logic [3:0] o, input logic [7:0] x);
      r = alu(o, ew, x, ef);
      sv = r;
      run(o, x, F_WORK);
      ew = sv[7:0];
      ef = sv[10:8];
      chk("work", {3'h0, work}, {3'h0, ew});
      chk("flags", {8'h00, status[2:0]}, {8'h00, ef});
      chk("pc", pc, epc);
   endtask : alu_step
   task automatic skip_step(input logic [3:0] o, input logic [7:0] x, input logic hit);
      r = {10'h000, hit};
      run(o, x, F_SKIP);
      chk("skip pc", pc, epc);
      chk("skip work", {3'h0, work}, {3'h0, ew});
   endtask : skip_step
   task automatic reg_io(input logic w, input logic [7:0] a, v);
      @(posedge mclk);
      {wr, rd} <= {w, !w};
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      {wr, rd} <= 2'h0;
      #1 d = rdata;
   endtask : reg_io
   task automatic do_reset;
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      #1 {ew, ef, epc} = 22'h0;
      chk("pc", pc, 11'h000);
      chk("work", {3'h0, work}, 11'h000);
      chk("flags", {8'h00, status[2:0]}, 11'h000);
   endtask : do_reset

   // ****************************************
   // tests
   // ****************************************
   initial begin
      {cause_ld, exec, d_work, d_pcl, skip, bexp, jump, int_e, push, pop, wr, rd} = 12'h000;
      {cause, bsel, op, opnd, addr, wdata, jaddr, ivec, r} = 66'h0;
      void'($urandom(32'h1467));
      do_reset();
      for (int c = 0; c < 4; c++) begin
         @(posedge mclk);
         cause <= c[1:0];
         cause_ld <= 1'b1;
         @(posedge mclk);
         cause_ld <= 1'b0;
         reg_io(1'b0, ADDR_PROGRAM_STATUS, 8'h00);
         chk("cause", {3'h0, d}, {3'h0, c[1:0], 6'h00});
      end
      reg_io(1'b0, 8'h87, 8'h00);
      chk("unmapped", {3'h0, d}, 11'h000);
      reg_io(1'b1, ADDR_PROGRAM_STATUS, 8'hff);
      reg_io(1'b0, ADDR_PROGRAM_STATUS, 8'h00);
      chk("status", {3'h0, d}, 11'h0c7);
      ef = 3'h7;
      $display("test registers done");
      for (int i = 0; i < 48; i++) begin
         if (i < 7) alu_step(CORNER_OP[i], CORNER_X[i]);
         else alu_step(OPS[$urandom_range(5)], 8'($urandom));
      end
      alu_step(OP_RLC, 8'h81);
      alu_step(OP_RRC, 8'h01);
      $display("test alu done");
      pushed = {ef, ew};
      run(OP_NONE, 8'h00, 7'h02);
      alu_step(OP_XOR, 8'h5a);
      run(OP_NONE, 8'h00, 7'h01);
      chk("pop", {status[2:0], work}, pushed);
      {ef, ew} = pushed;
      ivec = 11'h5a5;
      run(OP_ADD, 8'h33, F_WORK | F_INT);
      chk("int", {status[2:0], work}, pushed);
      chk("int pc", pc, 11'h5a5);
      $display("test save and interrupt done");
      for (int i = 0; i < 5; i++) begin
         jaddr = (i == 0) ? 11'h7ff : (i == 4 ? 11'h2f0 : 11'($urandom));
         run(OP_NONE, 8'h00, F_JUMP);
         chk("jump", pc, jaddr);
      end
      epc = 11'h2f0;
      alu_step(OP_AND, 8'h00);
      alu_step(OP_OR, 8'h20);
      run(OP_ADD, pc[7:0], F_PCL);
      chk("pc carry", {8'h00, pc[10:8]}, 11'h003);
      run(OP_SUB, pc[7:0], F_PCL);
      chk("pc borrow", {8'h00, pc[10:8]}, 11'h003);
      jaddr = 11'h100;
      run(OP_NONE, 8'h00, F_JUMP);
      epc = 11'h100;
      skip_step(OP_CMP, ew, 1'b1);
      skip_step(OP_CMP, ew ^ 8'h01, 1'b0);
      for (int i = 0; i < 16; i++) begin
         {bexp, bsel} = i[3:0];
         d = 8'($urandom);
         skip_step(OP_BTST, d, d[bsel] == bexp);
      end
      skip_step(OP_INC, 8'hff, 1'b1);
      chk("mem inc", {2'h0, mem_we, mem_wdata}, 11'h100);
      skip_step(OP_INC, 8'h7f, 1'b0);
      skip_step(OP_DEC, 8'h00, 1'b1);
      chk("mem dec", {3'h0, mem_wdata}, 11'h0ff);
      skip_step(OP_DEC, 8'h01, 1'b0);
      @(posedge mclk);
      #1 chk("mem last", {3'h0, last_wr}, 11'h000);
      $display("test counter and skips done");
      do_reset();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb
